// file: hw/pic_top.sv
/*
 * Priority interrupt controller top: register file on the peripheral
 * bus, level mapping, presentation to the core, fast vectors,
 * low-power wake request and boot address.
 * Assumes all inputs are synchronous to CLK_SYS.
 */
//
// Summary of operation
// R01 - Arbitrate requests, signal core, supply vector
// R02 - Three programmable levels per source, some fixed
// R03 - Same level: lowest source number wins
// R04 - Normal vector is base joined with number
// R05 - Core mask bits limit accepted levels
// R06 - Presented level field encodes current level
// R07 - Two fast interrupts with match and address
// R08 - Software sets level two, match, address
// R09 - Level-two match outputs stored fast address
// R10 - Fast interrupt known before the core
// R11 - Core skips fast handling on subroutine jump
// R12 - Pending request in low power wakes clocks
// R13 - Wake only if enabled before low power
// R14 - Drive initial fetch address after reset
// R15 - Bus slave at base plus offset
// R16 - Functional mode by default, else wait/stop
// R17 - Priority fields reset to disabled
// R18 - Code-to-level map differs among sources
// R19 - Present only highest unmasked pending request
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
#(
    parameter logic [VADDR_W-1:0] P_BOOT_ADDR = BOOT_ADDR_RST,
    parameter logic [55:0]        P_HIGH_MAP  = HIGH_MAP_RST
)(
    input  wire logic               CLK_SYS,
    input  wire logic               RESETN,
    input  wire logic [ADDR_W-1:0]  IPB_ADDR,
    input  wire logic [DATA_W-1:0]  IPB_WDATA,
    input  wire logic               IPB_WR,
    input  wire logic               IPB_RD,
    output logic      [DATA_W-1:0]  IPB_RDATA,
    input  wire logic [NUM_SRC-1:0] IRQ_REQ,
    input  wire logic [1:0]         CORE_MASK,
    input  wire logic               LP_WAIT,
    input  wire logic               LP_STOP,
    input  wire logic               CORE_BOOT_DONE,
    output logic                    IRQ_ASSERT,
    output logic      [1:0]         IRQ_LEVEL,
    output logic      [SRC_W-1:0]   IRQ_VECTOR,
    output logic      [VADDR_W-1:0] IRQ_VADDR,
    output logic                    IRQ_FAST,
    output logic                    BOOT_VALID,
    output logic                    WAKE_REQ
);
    pic_arb_if ab ();

    logic [DATA_W-1:0]  ipr_r [NUM_IPR];
    logic [DATA_W-1:0]  vba_r, fast_match_0_r, fast_vector_low_0_r, fast_vector_high_0_r;
    logic [DATA_W-1:0]  fast_match_1_r, fast_vector_low_1_r, fast_vector_high_1_r;
    logic               dis_r;
    logic [NUM_SRC-1:0] src_en, pend, snap_en_r;
    logic [1:0]         code [NUM_SRC];
    pic_mode_t          mode_r, mode_nxt;
    logic               boot_r;
    logic [DATA_W-1:0]  rdata_nxt, ctrl_rd;
    logic               allowed, fast0, fast1, wake_nxt;
    logic [1:0]         pres_nxt;
    logic [VADDR_W-1:0] vaddr_nxt;

    // Per-source level and enable; fixed sources always at top level
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
        if (s < NUM_FIXED) begin : g_fix
            assign code[s]   = LVL_FIXED;
            assign src_en[s] = 1'b1;
            assign ab.lvl[s] = LVL_FIXED; // R02
        end else begin : g_prog
            localparam int F = s - NUM_FIXED;
            assign code[s]   = ipr_r[F / FLD_PER][(F % FLD_PER) * 2 +: 2];
            assign src_en[s] = (code[s] != CODE_OFF); // R17
            assign ab.lvl[s] = P_HIGH_MAP[F] ? code[s]
                             : code[s] - 2'h1; // R18
        end
    end
    assign pend   = IRQ_REQ & src_en;
    assign ab.act = pend; // R01

    pic_arbiter u_arb (
        .bus (ab)
    );

    // Priority field registers; every field resets to disabled
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < NUM_IPR; i++) begin
                ipr_r[i] <= REG_RST; // R17
            end
        end else if (IPB_WR && IPB_ADDR <= OFF_IRQ_PRIORITY_6) begin
            ipr_r[IPB_ADDR[2:0]] <= IPB_WDATA; // R02
        end
    end

    // Vector base, fast match and fast address registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            vba_r    <= REG_RST;
            fast_match_0_r   <= REG_RST;
            fast_vector_low_0_r <= REG_RST;
            fast_vector_high_0_r <= REG_RST;
            fast_match_1_r   <= REG_RST;
            fast_vector_low_1_r <= REG_RST;
            fast_vector_high_1_r <= REG_RST;
            dis_r    <= 1'b0;
        end else if (IPB_WR) begin
            unique case (IPB_ADDR)
                OFF_VBA:    vba_r    <= IPB_WDATA;
                OFF_FAST_MATCH_0:   fast_match_0_r   <= IPB_WDATA; // R07
                OFF_FAST_VECTOR_LOW_0: fast_vector_low_0_r <= IPB_WDATA;
                OFF_FAST_VECTOR_HIGH_0: fast_vector_high_0_r <= IPB_WDATA;
                OFF_FAST_MATCH_1:   fast_match_1_r   <= IPB_WDATA;
                OFF_FAST_VECTOR_LOW_1: fast_vector_low_1_r <= IPB_WDATA;
                OFF_FAST_VECTOR_HIGH_1: fast_vector_high_1_r <= IPB_WDATA;
                OFF_CTRL:   dis_r    <= IPB_WDATA[CTRL_DIS_BIT];
                default:    dis_r    <= dis_r;
            endcase
        end
    end

    // Control register readback: own state plus core mask mirror
    assign ctrl_rd = {IRQ_ASSERT, IRQ_LEVEL, IRQ_VECTOR, WAKE_REQ,
                      dis_r, 3'h0, CORE_MASK};

    // Read selection; unmapped offsets read as zero
    always_comb begin
        rdata_nxt = REG_RST;
        if (IPB_ADDR <= OFF_IRQ_PRIORITY_6) begin
            rdata_nxt = ipr_r[IPB_ADDR[2:0]];
        end
        unique case (IPB_ADDR)
            OFF_VBA:    rdata_nxt = vba_r;
            OFF_FAST_MATCH_0:   rdata_nxt = fast_match_0_r;
            OFF_FAST_VECTOR_LOW_0: rdata_nxt = fast_vector_low_0_r;
            OFF_FAST_VECTOR_HIGH_0: rdata_nxt = fast_vector_high_0_r;
            OFF_FAST_MATCH_1:   rdata_nxt = fast_match_1_r;
            OFF_FAST_VECTOR_LOW_1: rdata_nxt = fast_vector_low_1_r;
            OFF_FAST_VECTOR_HIGH_1: rdata_nxt = fast_vector_high_1_r;
            OFF_PEND0:  rdata_nxt = pend[15:0];
            OFF_PEND1:  rdata_nxt = pend[31:16];
            OFF_PEND2:  rdata_nxt = pend[47:32];
            OFF_PEND3:  rdata_nxt = pend[63:48];
            OFF_CTRL:   rdata_nxt = ctrl_rd; // R06
            default:    rdata_nxt = rdata_nxt;
        endcase
    end

    // Registered read data, valid the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            IPB_RDATA <= REG_RST;
        end else if (IPB_RD) begin
            IPB_RDATA <= rdata_nxt; // R15
        end
    end

    // Operating mode: functional by default, wait and stop otherwise
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_FUNC: begin
                if (LP_STOP) begin
                    mode_nxt = MODE_STOP;
                end else if (LP_WAIT) begin
                    mode_nxt = MODE_WAIT;
                end
            end
            MODE_WAIT, MODE_STOP: begin
                if (!LP_WAIT && !LP_STOP) begin
                    mode_nxt = MODE_FUNC;
                end
            end
            default: mode_nxt = MODE_FUNC;
        endcase
    end

    // Mode register and enable snapshot taken on entry to low power
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            mode_r    <= MODE_FUNC; // R16
            snap_en_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            if (mode_r == MODE_FUNC && mode_nxt != MODE_FUNC) begin
                snap_en_r <= src_en; // R13
            end
        end
    end

    // Wake request only for sources enabled before entry
    assign wake_nxt = (mode_r != MODE_FUNC)
                      && |(IRQ_REQ & snap_en_r); // R12

    // Presentation gate: level at or above the core mask
    assign allowed = ab.win_valid && (ab.win_lvl >= CORE_MASK) // R05
                     && !dis_r && !boot_r && mode_r == MODE_FUNC; // R19
    assign pres_nxt = !allowed ? PRES_NONE :
                      ab.win_lvl == 2'h0 ? PRES_L0 :
                      ab.win_lvl == 2'h1 ? PRES_L1 : PRES_L23; // R06

    // Fast match only at level two, checked ahead of the core
    assign fast0 = ab.win_lvl == LVL_FAST
                   && ab.win_src == fast_match_0_r[SRC_W-1:0]; // R09
    assign fast1 = ab.win_lvl == LVL_FAST
                   && ab.win_src == fast_match_1_r[SRC_W-1:0]; // R08
    assign vaddr_nxt = boot_r ? P_BOOT_ADDR : // R14
        fast0 ? {fast_vector_high_0_r[FIVAH_W-1:0], fast_vector_low_0_r} :
        fast1 ? {fast_vector_high_1_r[FIVAH_W-1:0], fast_vector_low_1_r} :
        {vba_r[VBA_LSB_W-1:0], ab.win_src}; // R04

    // Boot address is driven until the core takes its first fetch
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            boot_r <= 1'b1;
        end else if (CORE_BOOT_DONE) begin
            boot_r <= 1'b0;
        end
    end

    // Registered outputs toward the core and clock unit
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            IRQ_ASSERT <= 1'b0;
            IRQ_LEVEL  <= PRES_NONE;
            IRQ_VECTOR <= '0;
            IRQ_VADDR  <= P_BOOT_ADDR;
            IRQ_FAST   <= 1'b0;
            BOOT_VALID <= 1'b1;
            WAKE_REQ   <= 1'b0;
        end else begin
            IRQ_ASSERT <= allowed; // R01
            IRQ_LEVEL  <= pres_nxt;
            IRQ_VECTOR <= ab.win_src;
            IRQ_VADDR  <= vaddr_nxt;
            IRQ_FAST   <= allowed && (fast0 || fast1); // R10
            BOOT_VALID <= boot_r && !CORE_BOOT_DONE;
            WAKE_REQ   <= wake_nxt;
        end
    end

    // Helper for checks: active sources at or above the winner
    logic [NUM_SRC-1:0] same_lvl, above_lvl;
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_chk
        assign same_lvl[s]  = ab.act[s] && ab.lvl[s] == ab.win_lvl;
        assign above_lvl[s] = ab.act[s] && ab.lvl[s] > ab.win_lvl;
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_enter_lp;
        mode_r == MODE_FUNC ##1 mode_r != MODE_FUNC;
    endsequence

    a_lowest_src_wins: assert property ( // R03
        ab.win_valid |-> ((same_lvl & ((64'h1 << ab.win_src) - 64'h1))
                          == '0) && above_lvl == '0)
        else $error("winner is not lowest number at top level");
    a_off_never_wins: assert property ( // R17
        ab.win_valid |-> src_en[ab.win_src])
        else $error("disabled source won arbitration");
    a_mask_blocks: assert property ( // R19
        ab.win_valid && ab.win_lvl < CORE_MASK |=> !IRQ_ASSERT)
        else $error("masked level presented to core");
    a_level_code: assert property ( // R06
        IRQ_ASSERT |-> IRQ_LEVEL == ($past(ab.win_lvl) == 2'h0 ? PRES_L0
            : $past(ab.win_lvl) == 2'h1 ? PRES_L1 : PRES_L23))
        else $error("presented level code wrong");
    a_fast_addr: assert property ( // R09
        allowed && fast0 |=> IRQ_FAST
            && IRQ_VADDR == {$past(fast_vector_high_0_r[FIVAH_W-1:0]), $past(fast_vector_low_0_r)})
        else $error("fast address not used on level two match");
    a_normal_addr: assert property ( // R04
        allowed && !fast0 && !fast1 |=> !IRQ_FAST
            && IRQ_VADDR == {$past(vba_r[VBA_LSB_W-1:0]), $past(ab.win_src)})
        else $error("normal vector address wrong");
    a_wake_needs_lp: assert property ( // R12
        WAKE_REQ |-> $past(mode_r) != MODE_FUNC)
        else $error("wake raised outside low power");
    a_wake_snapshot: assert property ( // R13
        s_enter_lp ##1 (mode_r != MODE_FUNC && (IRQ_REQ & snap_en_r) != '0)
        |=> WAKE_REQ)
        else $error("enabled request failed to wake");
    a_boot_addr: assert property ( // R14
        boot_r |=> IRQ_VADDR == P_BOOT_ADDR && !IRQ_ASSERT)
        else $error("boot address not driven");
    a_bus_read: assert property ( // R15
        IPB_RD && IPB_ADDR == OFF_VBA && !IPB_WR |=> IPB_RDATA == vba_r)
        else $error("vector base readback wrong");
endmodule

// file: shared/pic_pkg.sv
/*
 * Shared constants for the priority interrupt controller: register
 * offsets, field positions, reset values, widths and mode codes.
 * Assumes a word-addressed peripheral bus with 16-bit registers.
 */
package pic_pkg;
    // Source counts and widths
    localparam int NUM_SRC   = 64;
    localparam int SRC_W     = 6;
    localparam int NUM_FIXED = 8;
    localparam int NUM_IPR   = 7;
    localparam int FLD_PER   = 8;
    localparam int ADDR_W    = 5;
    localparam int DATA_W    = 16;
    localparam int VADDR_W   = 21;
    localparam int VBA_LSB_W = 15;
    localparam int FIVAH_W   = 5;

    // Register offsets (word addresses)
    localparam logic [4:0] OFF_IRQ_PRIORITY_0   = 5'h00;
    localparam logic [4:0] OFF_IRQ_PRIORITY_6   = 5'h06;
    localparam logic [4:0] OFF_VBA    = 5'h07;
    localparam logic [4:0] OFF_FAST_MATCH_0   = 5'h08;
    localparam logic [4:0] OFF_FAST_VECTOR_LOW_0 = 5'h09;
    localparam logic [4:0] OFF_FAST_VECTOR_HIGH_0 = 5'h0a;
    localparam logic [4:0] OFF_FAST_MATCH_1   = 5'h0b;
    localparam logic [4:0] OFF_FAST_VECTOR_LOW_1 = 5'h0c;
    localparam logic [4:0] OFF_FAST_VECTOR_HIGH_1 = 5'h0d;
    localparam logic [4:0] OFF_PEND0  = 5'h0e;
    localparam logic [4:0] OFF_PEND1  = 5'h0f;
    localparam logic [4:0] OFF_PEND2  = 5'h10;
    localparam logic [4:0] OFF_PEND3  = 5'h11;
    localparam logic [4:0] OFF_CTRL   = 5'h16;

    // Control register field positions
    localparam int CTRL_ASSERT_BIT = 15;
    localparam int CTRL_LEVEL_LSB  = 13;
    localparam int CTRL_VEC_LSB    = 7;
    localparam int CTRL_WAKE_BIT   = 6;
    localparam int CTRL_DIS_BIT    = 5;

    // Reset values
    localparam logic [15:0] REG_RST       = 16'h0000;
    localparam logic [20:0] BOOT_ADDR_RST = 21'h0_0000;

    // Levels and presented-level codes
    localparam logic [1:0] LVL_FIXED  = 2'h3;
    localparam logic [1:0] LVL_FAST   = 2'h2;
    localparam logic [1:0] CODE_OFF   = 2'h0;
    localparam logic [1:0] PRES_NONE  = 2'h0;
    localparam logic [1:0] PRES_L0    = 2'h1;
    localparam logic [1:0] PRES_L1    = 2'h2;
    localparam logic [1:0] PRES_L23   = 2'h3;

    // Sources whose codes 01..11 mean levels 1..3 (others 0..2)
    localparam logic [55:0] HIGH_MAP_RST = 56'h00_0000_0000_00ff;

    typedef enum logic [2:0] {
        MODE_FUNC = 3'b001,
        MODE_WAIT = 3'b010,
        MODE_STOP = 3'b100
    } pic_mode_t;
endpackage

// file: shared/pic_arb_if.sv
/*
 * Carrier between the controller top and its arbiter: per-source
 * activity and level in, winning source and level out.
 * Assumes both ends run on the same clock; the path is combinational.
 */
`timescale 1ns/1ps
interface pic_arb_if;
    import pic_pkg::*;
    logic [NUM_SRC-1:0] act;
    logic [1:0]         lvl [NUM_SRC];
    logic               win_valid;
    logic [1:0]         win_lvl;
    logic [SRC_W-1:0]   win_src;

    modport arb  (input act, lvl, output win_valid, win_lvl, win_src);
    modport user (output act, lvl, input win_valid, win_lvl, win_src);
endinterface

// file: hw/pic_arbiter.sv
/*
 * Combinational arbiter: highest level first, lowest source number
 * within a level. Assumes lvl is meaningful only where act is set.
 */
`timescale 1ns/1ps
module pic_arbiter
    import pic_pkg::*;
(
    pic_arb_if.arb bus
);
    logic [NUM_SRC-1:0] hit [4];
    logic [3:0]         any;

    // Index of the lowest set bit, source 0 ranks first
    function automatic logic [SRC_W-1:0] first_set(
        input logic [NUM_SRC-1:0] v);
        logic [SRC_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[SRC_W-1:0];
            end
        end
        return idx;
    endfunction

    // Split active requests by level
    for (genvar l = 0; l < 4; l++) begin : g_lvl
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
            assign hit[l][s] = bus.act[s] && (bus.lvl[s] == l[1:0]);
        end
        assign any[l] = |hit[l];
    end

    // Highest level wins, then the lowest number within it
    assign bus.win_valid = |any;
    assign bus.win_lvl   = any[3] ? 2'h3 : any[2] ? 2'h2 :
                           any[1] ? 2'h1 : 2'h0;
    assign bus.win_src   = first_set(hit[bus.win_lvl]); // R03
endmodule

// file: tb/pic_core_model.sv
/*
 * Behavioural model of the core and clock unit beside the controller:
 * takes the boot address, drives the status mask bits, enters fast
 * handling. Assumes one clock shared with the controller.
 */
`timescale 1ns/1ps
module pic_core_model
    import pic_pkg::*;
#(
    parameter int          P_BOOT_WAIT = 3,
    parameter logic [15:0] P_SUBR_OP   = 16'h00a5  // Arbitrary opcode
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        boot_valid,
    input  wire logic        irq_assert,
    input  wire logic        irq_fast,
    input  wire logic [1:0]  mask_want,
    input  wire logic [15:0] fetch_word,
    output logic             boot_done,
    output logic      [1:0]  core_mask,
    output logic             fast_entry
);
    int boot_cnt_r;

    // Mask bits follow the bench's choice, changed off the sampling edge
    assign core_mask = mask_want;

    // Take the boot address after a delay, then hold done high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_r <= 0;
            boot_done  <= 1'b0;
        end else if (boot_valid && !boot_done) begin
            boot_cnt_r <= boot_cnt_r + 1;
            boot_done  <= (boot_cnt_r >= P_BOOT_WAIT);
        end
    end

    // Fast handling only when the fetched word is no subroutine jump
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_entry <= 1'b0;
        end else begin
            fast_entry <= irq_assert && irq_fast && fetch_word != P_SUBR_OP;
        end
    end
endmodule

// file: tb/priority_interrupt_controller_bench.sv
/*
 * Self-checking bench for the interrupt controller: register map,
 * arbitration, fast vectors, boot address and low-power wake.
 * Assumes the package, the design and the core model are compiled.
 */
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
    import pic_pkg::*;
    localparam logic [VADDR_W-1:0] BOOT_ADDR = 21'h0_1234;
    logic               clk_sys   = 1'b0;
    logic               resetn    = 1'b0;
    logic [ADDR_W-1:0]  ipb_addr  = 5'h00;
    logic [DATA_W-1:0]  ipb_wdata = 16'h0000;
    logic               ipb_wr    = 1'b0;
    logic               ipb_rd    = 1'b0;
    logic [NUM_SRC-1:0] irq_req   = 64'h0000_0000_0000_0008;
    logic [1:0]         mask_want = 2'h0;
    logic               lp_wait   = 1'b0;
    logic               lp_stop   = 1'b0;
    logic [DATA_W-1:0]  ipb_rdata;
    logic               irq_assert, irq_fast, boot_valid, wake_req;
    logic               boot_done, fast_entry;
    logic [1:0]         irq_level, core_mask;
    logic [SRC_W-1:0]   irq_vector;
    logic [VADDR_W-1:0] irq_vaddr;
    logic [15:0]        shadow [32];
    logic [15:0]        d;
    logic [31:0]        rnd;
    logic [8:0]         w;
    int                 miscompares = 0;
    int                 samples_checked = 0;
    int                 seed = 32'h2c85479c;

    always #2 clk_sys = ~clk_sys;

    pic_top #(.P_BOOT_ADDR(BOOT_ADDR)) i_dut (
        .CLK_SYS(clk_sys), .RESETN(resetn), .IPB_ADDR(ipb_addr),
        .IPB_WDATA(ipb_wdata), .IPB_WR(ipb_wr), .IPB_RD(ipb_rd),
        .IPB_RDATA(ipb_rdata), .IRQ_REQ(irq_req), .CORE_MASK(core_mask),
        .LP_WAIT(lp_wait), .LP_STOP(lp_stop), .CORE_BOOT_DONE(boot_done),
        .IRQ_ASSERT(irq_assert), .IRQ_LEVEL(irq_level),
        .IRQ_VECTOR(irq_vector), .IRQ_VADDR(irq_vaddr),
        .IRQ_FAST(irq_fast), .BOOT_VALID(boot_valid), .WAKE_REQ(wake_req));

    pic_core_model #(.P_BOOT_WAIT(3)) i_core (
        .clk(clk_sys), .rst_n(resetn), .boot_valid(boot_valid),
        .irq_assert(irq_assert), .irq_fast(irq_fast),
        .mask_want(mask_want), .fetch_word(irq_vaddr[15:0]),
        .boot_done(boot_done), .core_mask(core_mask),
        .fast_entry(fast_entry));

    // Enable bit and level of one source from the shadow fields
    function automatic logic [2:0] src_lvl(int s);
        logic [1:0] code;
        if (s < NUM_FIXED) return {1'b1, LVL_FIXED};
        code = shadow[(s - 8) / 8][((s - 8) % 8) * 2 +: 2];
        if (code == CODE_OFF) return 3'h0;
        if (s < 16) return {1'b1, code};
        return {1'b1, code - 2'h1};
    endfunction

    // Highest level first, then lowest source number
    function automatic logic [8:0] winner(logic [63:0] r);
        logic [2:0] e;
        for (int l = 3; l >= 0; l--)
            for (int s = 0; s < NUM_SRC; s++) begin
                e = src_lvl(s);
                if (r[s] && e[2] && e[1:0] == l[1:0])
                    return {1'b1, e[1:0], s[5:0]};
            end
        return 9'h000;
    endfunction

    // Expected read data; pending flags are request and enable
    function automatic logic [15:0] exp_rd(logic [4:0] a);
        logic [15:0] p;
        logic [2:0]  e;
        if (a <= OFF_FAST_VECTOR_HIGH_1) return shadow[a];
        if (a > OFF_PEND3) return 16'h0000;
        for (int n = 0; n < 16; n++) begin
            e = src_lvl(16 * (a - OFF_PEND0) + n);
            p[n] = irq_req[16 * (a - OFF_PEND0) + n] & e[2];
        end
        return p;
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [4:0] a, logic [15:0] v);
        @(negedge clk_sys);
        ipb_addr  = a;
        ipb_wdata = v;
        ipb_wr    = 1'b1;
        @(negedge clk_sys);
        ipb_wr = 1'b0;
        if (a <= OFF_FAST_VECTOR_HIGH_1 || a == OFF_CTRL) shadow[a] = v;
    endtask

    task automatic rd(logic [4:0] a);
        @(negedge clk_sys);
        ipb_addr = a;
        ipb_rd   = 1'b1;
        @(negedge clk_sys);
        ipb_rd = 1'b0;
        d = ipb_rdata;
    endtask

    // Compare what is presented to the core with the prediction
    task automatic check_out();
        logic        pres, f0, f1;
        logic [20:0] va;
        w    = winner(irq_req);
        pres = w[8] && w[7:6] >= core_mask && !shadow[OFF_CTRL][CTRL_DIS_BIT];
        chk(irq_assert, pres);
        if (pres) begin
            f0 = w[7:6] == LVL_FAST && shadow[OFF_FAST_MATCH_0][5:0] == w[5:0];
            f1 = w[7:6] == LVL_FAST && shadow[OFF_FAST_MATCH_1][5:0] == w[5:0];
            va = {shadow[OFF_VBA][14:0], w[5:0]};
            if (f1) va = {shadow[OFF_FAST_VECTOR_HIGH_1][4:0], shadow[OFF_FAST_VECTOR_LOW_1]};
            if (f0) va = {shadow[OFF_FAST_VECTOR_HIGH_0][4:0], shadow[OFF_FAST_VECTOR_LOW_0]};
            chk(irq_level, w[7:6] == 2'h3 ? 2'h3 : w[7:6] + 2'h1);
            chk(irq_vector, w[5:0]);
            chk(irq_fast, f0 | f1);
            chk(irq_vaddr, va);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        test_done();
    end

    initial begin
        foreach (shadow[i]) shadow[i] = 16'h0000;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        chk(boot_valid, 1'b1);
        chk(irq_vaddr, BOOT_ADDR);
        chk(irq_assert, 1'b0);
        for (int a = 0; a < 32; a++) if (a != OFF_CTRL) begin
            rd(a[4:0]);
            chk(d, exp_rd(a[4:0]));
        end
        check_out();
        $display("test reset_map done");
        // Two fast interrupts at level two, both code maps
        for (int k = 0; k < 2; k++) begin
            rnd = $random(seed);
            wr(k ? OFF_IRQ_PRIORITY_0 + 5'h04 : OFF_IRQ_PRIORITY_0, k ? 16'h0003 : 16'h0008);
            wr(k ? OFF_FAST_MATCH_1 : OFF_FAST_MATCH_0, k ? 16'h0028 : 16'h0009);
            wr(k ? OFF_FAST_VECTOR_LOW_1 : OFF_FAST_VECTOR_LOW_0, rnd[15:0]);
            wr(k ? OFF_FAST_VECTOR_HIGH_1 : OFF_FAST_VECTOR_HIGH_0, rnd[31:16]);
            irq_req   = 64'h1 << (k ? 40 : 9);
            mask_want = 2'h2;
            repeat (2) @(negedge clk_sys);
            check_out();
            chk(fast_entry, rnd[15:0] != 16'h00a5);
            mask_want = 2'h3;
            repeat (2) @(negedge clk_sys);
            check_out();
        end
        $display("test fast done");
        for (int i = 0; i < 60; i++) begin
            for (int r = 0; r <= 13; r++) begin
                rnd = $random(seed);
                wr(r[4:0], rnd[15:0]);
            end
            irq_req[31:0]  = $random(seed) & $random(seed);
            irq_req[63:32] = $random(seed) & $random(seed);
            if (i % 4 != 0) irq_req[7:0] = 8'h00;
            mask_want = rnd[17:16];
            wr(OFF_CTRL, (i % 8 == 5) ? 16'h0020 : 16'h0000);
            w = winner(irq_req);
            if (i % 2) begin
                wr(OFF_FAST_MATCH_0, {10'h000, w[5:0] ^ {5'h00, i[1]}});
                wr(OFF_FAST_MATCH_1, {10'h000, w[5:0] ^ {5'h00, !i[1]}});
            end
            repeat (2) @(negedge clk_sys);
            check_out();
            rnd = $random(seed);
            if (rnd[4:0] != OFF_CTRL) begin
                rd(rnd[4:0]);
                chk(d, exp_rd(rnd[4:0]));
            end
        end
        $display("test random done");
        for (int r = 0; r <= 6; r++) wr(r[4:0], 16'h0100 & {16{r == 1}});
        irq_req   = 64'h0;
        mask_want = 2'h0;
        for (int m = 0; m < 2; m++) begin
            lp_wait = (m == 0);
            lp_stop = (m == 1);
            repeat (2) @(negedge clk_sys);
            chk(wake_req, 1'b0);
            wr(OFF_IRQ_PRIORITY_0 + 5'h01, 16'h0500);
            irq_req[21] = 1'b1;
            repeat (3) @(negedge clk_sys);
            chk(wake_req, 1'b0);
            chk(irq_assert, 1'b0);
            irq_req[21] = 1'b0;
            irq_req[20] = 1'b1;
            repeat (2) @(negedge clk_sys);
            chk(wake_req, 1'b1);
            lp_wait     = 1'b0;
            lp_stop     = 1'b0;
            irq_req[20] = 1'b0;
            wr(OFF_IRQ_PRIORITY_0 + 5'h01, 16'h0100);
            repeat (2) @(negedge clk_sys);
            chk(wake_req, 1'b0);
        end
        irq_req[20] = 1'b1;
        repeat (2) @(negedge clk_sys);
        check_out();
        // Request already standing as wait mode is entered
        lp_wait = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(wake_req, 1'b1);
        lp_wait = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(wake_req, 1'b0);
        $display("test low_power done");
        test_done();
    end
endmodule
